/* File: rtl/irpc_top.sv */
// Infrared 3/16 pulse encoder and pulse-stretching decoder
`timescale 1ns/1ps
module irpc_top (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic oversample_clock_i,
    input  wire logic uart_serial_out_i,
    input  wire logic optical_pulse_in_i,
    input  wire logic decode_reset_n_i,
    output logic      optical_pulse_out_o,
    output logic      uart_rx_out_o,
    output logic      req_overflow_o
);

    // Falling edge between the previous and current synchronised sample
    function automatic logic fell(input logic prev, input logic now);
        fell = prev & ~now;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers: two flops per pin, then one history flop
    // ------------------------------------------------------------------
    irpc_pkg::irpc_pins_s pins_raw;
    irpc_pkg::irpc_pins_s meta_q;
    irpc_pkg::irpc_pins_s sync_q;
    irpc_pkg::irpc_pins_s hist_q;

    assign pins_raw.tx_line    = uart_serial_out_i;
    assign pins_raw.optical_in = optical_pulse_in_i;
    assign pins_raw.ovs_clk    = oversample_clock_i;
    assign pins_raw.dec_rst_n  = decode_reset_n_i;

    localparam logic [irpc_pkg::PIN_COUNT-1:0] PIN_RST = irpc_pkg::PINS_RESET;

    genvar gi;
    generate
        for (gi = 0; gi < irpc_pkg::PIN_COUNT; gi++) begin : g_sync
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_q[gi] <= PIN_RST[gi];
                    sync_q[gi] <= PIN_RST[gi];
                    hist_q[gi] <= PIN_RST[gi];
                end else begin
                    meta_q[gi] <= pins_raw[gi];
                    sync_q[gi] <= meta_q[gi];
                    hist_q[gi] <= sync_q[gi];
                end
            end
        end
    endgenerate

    // One-cycle enable on each rising edge of the oversampling clock
    wire logic ovs_tick = hist_q.ovs_clk == 1'b0 && sync_q.ovs_clk == 1'b1;
    wire logic tx_fall  = fell(hist_q.tx_line, sync_q.tx_line);
    wire logic opt_fall = fell(hist_q.optical_in, sync_q.optical_in);
    wire logic dec_en   = sync_q.dec_rst_n;

    // ------------------------------------------------------------------
    // Encoder front: a captured space edge waits here until queued
    // ------------------------------------------------------------------
    logic                    pend_q;
    logic                    pend_d;
    logic                    ovf_q;
    logic                    ovf_d;
    logic                    req_wr_ready;
    logic                    req_rd_valid;
    logic                    req_rd_ready;
    irpc_pkg::irpc_enc_req_s req_wr;
    irpc_pkg::irpc_enc_req_s req_rd;

    assign req_wr.wait_ticks = irpc_pkg::ENC_WAIT_TICKS;
    assign req_wr.high_ticks = irpc_pkg::ENC_HIGH_TICKS;

    // A new edge wins over the clear of the pending flag
    assign pend_d = tx_fall | (pend_q & ~req_wr_ready);
    // Sticky indication that an edge merged into one still waiting
    assign ovf_d  = ovf_q | (tx_fall & pend_q & ~req_wr_ready);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_q <= 1'b0;
            ovf_q  <= 1'b0;
        end else begin
            pend_q <= pend_d;
            ovf_q  <= ovf_d;
        end
    end

    irpc_fifo #(
        .WIDTH (irpc_pkg::REQ_FIFO_WIDTH),
        .DEPTH (irpc_pkg::REQ_FIFO_DEPTH)
    ) u_req_fifo (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .wr_data_i  (req_wr),
        .wr_valid_i (pend_q),
        .wr_ready_o (req_wr_ready),
        .rd_data_o  (req_rd),
        .rd_valid_o (req_rd_valid),
        .rd_ready_i (req_rd_ready)
    );

    // ------------------------------------------------------------------
    // Encoder shaper: only the async system reset touches it
    // ------------------------------------------------------------------
    irpc_pkg::irpc_enc_state_e enc_state_q;
    irpc_pkg::irpc_enc_state_e enc_state_d;
    logic [3:0]                enc_cnt_q;
    logic [3:0]                enc_cnt_d;
    logic [3:0]                enc_high_q;
    logic [3:0]                enc_high_d;
    logic                      enc_out_q;
    logic                      enc_out_d;

    // Shaper takes a request only when idle, which back-pressures the queue
    assign req_rd_ready = (enc_state_q == irpc_pkg::ENC_IDLE);

    always_comb begin
        enc_state_d = enc_state_q;
        enc_cnt_d   = enc_cnt_q;
        enc_high_d  = enc_high_q;
        enc_out_d   = enc_out_q;
        case (enc_state_q)
            irpc_pkg::ENC_IDLE: begin
                enc_out_d = irpc_pkg::OPT_OUT_IDLE;
                if (req_rd_valid) begin
                    enc_cnt_d   = req_rd.wait_ticks;
                    enc_high_d  = req_rd.high_ticks;
                    enc_state_d = irpc_pkg::ENC_WAIT;
                end
            end
            irpc_pkg::ENC_WAIT: begin
                if (ovs_tick) begin
                    if (enc_cnt_q == 4'h1) begin
                        enc_out_d   = ~irpc_pkg::OPT_OUT_IDLE;
                        enc_cnt_d   = enc_high_q;
                        enc_state_d = irpc_pkg::ENC_PULSE;
                    end else begin
                        enc_cnt_d = enc_cnt_q - 4'h1;
                    end
                end
            end
            irpc_pkg::ENC_PULSE: begin
                if (ovs_tick) begin
                    if (enc_cnt_q == 4'h1) begin
                        enc_out_d   = irpc_pkg::OPT_OUT_IDLE;
                        enc_state_d = irpc_pkg::ENC_IDLE;
                    end else begin
                        enc_cnt_d = enc_cnt_q - 4'h1;
                    end
                end
            end
            default: begin
                enc_out_d   = irpc_pkg::OPT_OUT_IDLE;
                enc_state_d = irpc_pkg::ENC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enc_state_q <= irpc_pkg::ENC_IDLE;
            enc_cnt_q   <= 4'h0;
            enc_high_q  <= 4'h0;
            enc_out_q   <= irpc_pkg::OPT_OUT_IDLE;
        end else begin
            enc_state_q <= enc_state_d;
            enc_cnt_q   <= enc_cnt_d;
            enc_high_q  <= enc_high_d;
            enc_out_q   <= enc_out_d;
        end
    end

    // ------------------------------------------------------------------
    // Decoder: stretches each optical pulse into one space bit
    // ------------------------------------------------------------------
    // Sixteen ticks is above the three-quarter-bit floor a UART needs
    localparam logic STRETCH_OK =
        (irpc_pkg::DEC_STRETCH_TICKS >= irpc_pkg::DEC_MIN_LOW_TICKS);

    irpc_pkg::irpc_dec_state_e dec_state_q;
    irpc_pkg::irpc_dec_state_e dec_state_d;
    logic [4:0]                dec_cnt_q;
    logic [4:0]                dec_cnt_d;
    logic                      rx_q;
    logic                      rx_d;

    always_comb begin
        dec_state_d = dec_state_q;
        dec_cnt_d   = dec_cnt_q;
        rx_d        = rx_q;
        if (!dec_en) begin
            // Held idle: the UART sees a steady mark, nothing is received
            dec_state_d = irpc_pkg::DEC_IDLE;
            dec_cnt_d   = 5'h00;
            rx_d        = irpc_pkg::RX_OUT_IDLE;
        end else if (opt_fall && STRETCH_OK) begin
            // A pulse mid-stretch restarts the bit time from its own edge
            dec_state_d = irpc_pkg::DEC_STRETCH;
            dec_cnt_d   = irpc_pkg::DEC_STRETCH_TICKS;
            rx_d        = ~irpc_pkg::RX_OUT_IDLE;
        end else begin
            case (dec_state_q)
                irpc_pkg::DEC_IDLE: begin
                    rx_d = irpc_pkg::RX_OUT_IDLE;
                end
                irpc_pkg::DEC_STRETCH: begin
                    if (ovs_tick) begin
                        if (dec_cnt_q == 5'h01) begin
                            rx_d        = irpc_pkg::RX_OUT_IDLE;
                            dec_state_d = irpc_pkg::DEC_IDLE;
                        end else begin
                            dec_cnt_d = dec_cnt_q - 5'h01;
                        end
                    end
                end
                default: begin
                    rx_d        = irpc_pkg::RX_OUT_IDLE;
                    dec_state_d = irpc_pkg::DEC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dec_state_q <= irpc_pkg::DEC_IDLE;
            dec_cnt_q   <= 5'h00;
            rx_q        <= irpc_pkg::RX_OUT_IDLE;
        end else begin
            dec_state_q <= dec_state_d;
            dec_cnt_q   <= dec_cnt_d;
            rx_q        <= rx_d;
        end
    end

    assign optical_pulse_out_o = enc_out_q;
    assign uart_rx_out_o       = rx_q;
    assign req_overflow_o      = ovf_q;

endmodule

/* File: shared/irpc_pkg.sv */
// Shared constants, types and state encodings of the infrared pulse codec
package irpc_pkg;

    // Oversampling ticks per serial bit
    localparam int unsigned OVS_PER_BIT       = 16;

    // Encoder timing, in oversampling ticks
    localparam logic [3:0]  ENC_WAIT_TICKS    = 4'h7;
    localparam logic [3:0]  ENC_HIGH_TICKS    = 4'h3;

    // Decoder stretch: one whole bit time
    localparam logic [4:0]  DEC_STRETCH_TICKS = 5'h10;
    // Shortest low period a receiving UART accepts: three quarters of a bit
    localparam logic [4:0]  DEC_MIN_LOW_TICKS = 5'h0C;

    // Request queue between edge capture and pulse shaper
    localparam int unsigned REQ_FIFO_DEPTH    = 8;
    localparam int unsigned REQ_FIFO_WIDTH    = 8;

    // Number of pins brought through synchronisers
    localparam int unsigned PIN_COUNT         = 4;

    // Idle levels of the lines, also their reset values
    localparam logic        TX_LINE_IDLE      = 1'b1;
    localparam logic        OPT_IN_IDLE       = 1'b1;
    localparam logic        OVS_CLK_IDLE      = 1'b0;
    localparam logic        DEC_RST_IDLE      = 1'b0;
    localparam logic        RX_OUT_IDLE       = 1'b1;
    localparam logic        OPT_OUT_IDLE      = 1'b0;

    // One queued pulse request: how long to wait and how long to stay high
    typedef struct packed {
        logic [3:0] wait_ticks;
        logic [3:0] high_ticks;
    } irpc_enc_req_s;

    // Asynchronous pins, bundled so one synchroniser loop covers them all
    typedef struct packed {
        logic tx_line;
        logic optical_in;
        logic ovs_clk;
        logic dec_rst_n;
    } irpc_pins_s;

    localparam irpc_pins_s PINS_RESET = '{
        tx_line:    TX_LINE_IDLE,
        optical_in: OPT_IN_IDLE,
        ovs_clk:    OVS_CLK_IDLE,
        dec_rst_n:  DEC_RST_IDLE
    };

    typedef enum logic [2:0] {
        ENC_IDLE  = 3'b001,
        ENC_WAIT  = 3'b010,
        ENC_PULSE = 3'b100
    } irpc_enc_state_e;

    typedef enum logic [1:0] {
        DEC_IDLE    = 2'b01,
        DEC_STRETCH = 2'b10
    } irpc_dec_state_e;

endpackage

/* File: rtl/irpc_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module irpc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    input  wire logic             wr_valid_i,
    output logic                  wr_ready_o,
    output logic      [WIDTH-1:0] rd_data_o,
    output logic                  rd_valid_o,
    input  wire logic             rd_ready_i
);

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      count_q;

    wire logic full  = (count_q == FULL_COUNT);
    wire logic empty = (count_q == '0);
    wire logic push  = wr_valid_i & ~full;
    wire logic pop   = rd_ready_i & ~empty;

    assign wr_ready_o = ~full;
    assign rd_valid_o = ~empty;
    // Head word comes straight from the storage flops
    assign rd_data_o  = mem_q[rd_ptr_q];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == LAST_SLOT) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == LAST_SLOT) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule

/* File: verif/irpc_monitor.sv */
// Pin-level checker of the infrared pulse codec
`timescale 1ns/1ps
module irpc_monitor (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic oversample_clock_i,
    input wire logic uart_serial_out_i,
    input wire logic optical_pulse_in_i,
    input wire logic decode_reset_n_i,
    input wire logic optical_pulse_out_o,
    input wire logic uart_rx_out_o,
    input wire logic req_overflow_o
);
    logic       ovs_q, tx_q, rin_q, pout_q;
    logic [7:0] hi_q, lo_q, wt_q, sf_q, gap_q, owed_q;
    wire        tick   = oversample_clock_i & ~ovs_q;
    wire        tx_f   = tx_q & ~uart_serial_out_i;
    wire        rin_f  = rin_q & ~optical_pulse_in_i;
    wire        pout_r = optical_pulse_out_o & ~pout_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Tick counters use the raw pin; the codec's own sync delay shifts both ends equally
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {ovs_q, tx_q, rin_q, pout_q} <= 4'h6;
            {hi_q, lo_q, wt_q, sf_q, gap_q, owed_q} <= '0;
        end else begin
            {ovs_q, tx_q, rin_q, pout_q} <= {oversample_clock_i, uart_serial_out_i,
                                             optical_pulse_in_i, optical_pulse_out_o};
            hi_q   <= optical_pulse_out_o ? hi_q + 8'(tick) : 8'h00;
            // Saturate so a long idle spell never wraps below the seven-tick floor
            wt_q   <= optical_pulse_out_o ? 8'h00 : wt_q + 8'(tick && wt_q != 8'hFF);
            lo_q   <= uart_rx_out_o ? 8'h00 : lo_q + 8'(tick);
            sf_q   <= rin_f ? 8'h00 : sf_q + 8'(tick);
            gap_q  <= rin_f ? 8'h00 : gap_q + 8'(gap_q != 8'hFF);
            owed_q <= owed_q + 8'(tx_f) - 8'(pout_r);
        end
    end

    AST_RST_IDLE: assert property (
        $rose(rst_n_i) |-> uart_rx_out_o && !optical_pulse_out_o && !req_overflow_o)
        else $error("outputs not idle after reset");
    AST_ENC_WIDTH: assert property (
        $fell(optical_pulse_out_o) |-> hi_q == 8'h03)
        else $error("optical pulse not three ticks wide");
    AST_ENC_WAIT: assert property (
        $rose(optical_pulse_out_o) |-> wt_q >= 8'h07)
        else $error("optical pulse started before seven ticks");
    AST_ENC_CAUSE: assert property (
        $rose(optical_pulse_out_o) |-> owed_q != 8'h00)
        else $error("optical pulse without a space edge");
    AST_ENC_ANSWER: assert property (
        tx_f && owed_q == 8'h00 && !optical_pulse_out_o |-> ##[1:300] $rose(optical_pulse_out_o))
        else $error("space edge made no optical pulse");
    AST_RX_STRETCH: assert property (
        $rose(uart_rx_out_o) |-> sf_q inside {[8'h0F:8'h11]})
        else $error("receive low not sixteen ticks after last pulse");
    AST_RX_MIN: assert property (
        $rose(uart_rx_out_o) |-> lo_q >= 8'h0C)
        else $error("receive low shorter than three quarter bit");
    AST_DEC_ACCEPT: assert property (
        $fell(uart_rx_out_o) |-> gap_q <= 8'h05)
        else $error("receive low without an optical falling edge");
    AST_DEC_OFF: assert property (
        !decode_reset_n_i [*5] |-> uart_rx_out_o)
        else $error("decoder active while disabled");
    AST_OVF_HOLD: assert property (
        req_overflow_o |=> req_overflow_o)
        else $error("overflow flag dropped");
endmodule

bind irpc_top irpc_monitor irpc_monitor_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .oversample_clock_i(oversample_clock_i),
    .uart_serial_out_i(uart_serial_out_i), .optical_pulse_in_i(optical_pulse_in_i),
    .decode_reset_n_i(decode_reset_n_i), .optical_pulse_out_o(optical_pulse_out_o),
    .uart_rx_out_o(uart_rx_out_o), .req_overflow_o(req_overflow_o));

/* File: verif/irpc_far_end.sv */
// Far-side model: baud-rate clock, UART transmit line and optical receiver
`timescale 1ns/1ps
module irpc_far_end #(
    parameter int HALF = 6
) (
    input  wire logic clk_i,
    output logic      ovs_o,
    output logic      tx_o,
    output logic      opt_o
);
    int ph = 0;

    initial begin
        ovs_o = 1'b0;
        tx_o  = 1'b1;
        opt_o = 1'b1;
    end

    // Free-running like a baud output; a 12 clk period stays under 2 MHz
    always @(posedge clk_i) begin
        ph    <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
        ovs_o <= #1 (ph < HALF);
    end

    task automatic tx_bit(input logic b, input int ticks);
        @(posedge clk_i);
        #1 tx_o = b;
        repeat (ticks) @(posedge ovs_o);
    endtask

    // Receiver output goes low for three ticks per received flash
    task automatic ir_pulse(input int gap);
        @(posedge clk_i);
        #1 opt_o = 1'b0;
        repeat (3) @(posedge ovs_o);
        @(posedge clk_i);
        #1 opt_o = 1'b1;
        repeat (gap) @(posedge ovs_o);
    endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench of the infrared pulse codec against expected pulse counts and tick widths
`timescale 1ns/1ps
`define CMP(act, exp) \
    begin \
        n_compared++; \
        if ((act) !== (exp)) begin \
            err_count++; \
            $display("CHECK FAILED t=%0t act=%0h exp=%0h", $time, (act), (exp)); \
        end \
    end
module testbench;
    logic       clk, rst_n, dec_n, ovs, tx, opt, pout, rx, ovf, prev;
    logic [9:0] frame;
    int         err_count, n_compared, seed, n_pulse, hi_t, lo_t, dly_t, exp_n, base;
    int         q_hi[$], q_lo[$], q_dly[$];

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    irpc_far_end irpc_far_end_i (.clk_i(clk), .ovs_o(ovs), .tx_o(tx), .opt_o(opt));
    irpc_top irpc_top_i (.clk_i(clk), .rst_n_i(rst_n), .oversample_clock_i(ovs),
        .uart_serial_out_i(tx), .optical_pulse_in_i(opt), .decode_reset_n_i(dec_n),
        .optical_pulse_out_o(pout), .uart_rx_out_o(rx), .req_overflow_o(ovf));

    // Measured in oversampling ticks, the unit the codec's timing is defined in
    always @(posedge ovs) begin
        hi_t  += int'(pout === 1'b1);
        lo_t  += int'(rx === 1'b0);
        dly_t += int'(pout === 1'b0);
    end
    always @(negedge tx) dly_t = 0;
    always @(negedge rx) lo_t = 0;
    always @(posedge rx) if (lo_t > 0) q_lo.push_back(lo_t);
    always @(negedge pout) if (hi_t > 0) q_hi.push_back(hi_t);
    always @(posedge pout) begin
        n_pulse++;
        q_dly.push_back(dly_t);
        hi_t = 0;
    end

    task automatic check_enc(input int n);
        `CMP(n_pulse - base, n)
        foreach (q_hi[i]) `CMP(q_hi[i], 3)
        foreach (q_dly[i]) `CMP(q_dly[i], 7)
        base = n_pulse;
        q_hi.delete();
        q_dly.delete();
    endtask

    task automatic check_dec(input int n);
        `CMP(q_lo.size(), 1)
        foreach (q_lo[i]) `CMP(q_lo[i], n)
        q_lo.delete();
    endtask

    task automatic summarize();
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        dec_n = 1'b0;
        seed  = 96;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        dec_n = 1'b1;
        @(posedge clk);
        #1 `CMP({rx, pout, ovf}, 3'h4)
        @(posedge ovs);
        irpc_far_end_i.tx_bit(1'b0, 16);
        irpc_far_end_i.tx_bit(1'b1, 32);
        check_enc(1);
        // Random frames while the decoder runs at the same time
        for (int f = 0; f < 4; f++) begin
            frame = {1'b1, 8'($random(seed)), 1'b0};
            prev  = 1'b1;
            exp_n = 0;
            for (int b = 0; b < 10; b++) begin
                exp_n += int'(prev && !frame[b]);
                prev = frame[b];
            end
            fork
                for (int b = 0; b < 10; b++) irpc_far_end_i.tx_bit(frame[b], 16);
                irpc_far_end_i.ir_pulse(20);
            join
            irpc_far_end_i.tx_bit(1'b1, 16);
            check_enc(exp_n);
            check_dec(16);
        end
        irpc_far_end_i.ir_pulse(5);
        irpc_far_end_i.ir_pulse(20);
        check_dec(3 + 5 + 16);
        @(posedge clk);
        #1 dec_n = 1'b0;
        repeat (2) @(posedge ovs);
        fork
            irpc_far_end_i.ir_pulse(20);
            irpc_far_end_i.tx_bit(1'b0, 16);
        join
        irpc_far_end_i.tx_bit(1'b1, 16);
        `CMP(q_lo.size(), 0)
        `CMP(rx, 1'b1)
        check_enc(1);
        @(posedge clk);
        #1 dec_n = 1'b1;
        // Edges two ticks apart outrun the shaper until the queue refuses
        for (int i = 0; i < 20; i++) begin
            irpc_far_end_i.tx_bit(1'b0, 1);
            irpc_far_end_i.tx_bit(1'b1, 1);
        end
        `CMP(ovf, 1'b1)
        irpc_far_end_i.tx_bit(1'b1, 250);
        q_dly.delete();
        `CMP(n_pulse - base >= 10 && n_pulse - base < 20, 1'b1)
        foreach (q_hi[i]) `CMP(q_hi[i], 3)
        summarize();
    end

    // About 1100 ticks of 600 ns are needed; this allows several times that
    initial begin
        #3000000;
        err_count++;
        summarize();
    end
endmodule
